/* File: src/psc_regs.svh */
`ifndef PSC_REGS_SVH
`define PSC_REGS_SVH

// Control word field and pin constants
`define PSC_CON_SIDL_BIT 13
`define PSC_OD_DIR       2'h3
`define PSC_BIT_FIRST    4'h0
`define PSC_BIT_ACK      4'h8
`define PSC_ADDR_LAST    4'h7
`define PSC_SHIFT_RST    8'h00
`define PSC_PIN_LOW      1'b0

`endif

/* File: src/psc_pkg.sv */
package psc_pkg;

    // One bit for each wire of the two-wire bus
    typedef struct packed {
        logic scl;
        logic sda;
    } psc_pins_type;

    typedef enum logic [2:0] {
        M_IDLE,
        M_START,
        M_LOW,
        M_HIGH,
        M_STOP,
        M_STOPH
    } psc_mst_state_type;

    typedef enum logic [1:0] {
        S_IDLE,
        S_ADDR,
        S_ACK,
        S_WAIT
    } psc_slv_state_type;

endpackage

/* File: src/psc_power_ctl.sv */
`timescale 1ns/1ps
`include "psc_regs.svh"
// Contract
// R1 - Sleep stops module clocks and bit-rate generator
// R2 - Sleep mid-transfer abandons the master transfer
// R3 - Software delays sleep until transfers finish
// R4 - Sleep entry and exit keep register values
// R5 - Slave keeps running from external serial clock
// R6 - Sleep slave interrupt only on address match
// R7 - Software avoids sleep during slave transmission
// R8 - Idle keeps clocks; stopping module gates itself
// R9 - Control bit 13 selects stop in idle
// R10 - Stop in idle acts as sleep, resets machines
// R11 - Any reset disables module, ends all messages
// R12 - Active bus function overrides pin direction bits
// R13 - Clock and data pins are open drain
// R14 - Wake after abort: master idle, generator reloaded
module psc_power_ctl
    import psc_pkg::*;
#(
    parameter int BRG_W = 12
)
(
    input  wire logic               sys_clk_i,
    input  wire logic               reset_n_i,
    input  wire logic               module_enable_i,
    input  wire logic               sleep_i,
    input  wire logic               idle_i,
    input  wire logic [15:0]        bus_control_register_i,
    input  wire logic [BRG_W-1:0]   mst_brg_reload_i,
    input  wire logic               mst_start_i,
    input  wire logic [7:0]         mst_data_i,
    input  wire logic [6:0]         slave_addr_i,
    input  wire logic               slave_irq_en_i,
    input  wire logic [1:0]         pin_direction_bits_i,
    input  wire psc_pins_type       pins_in_i,
    output psc_pins_type            pins_out_o,
    output psc_pins_type            pins_oe_o,
    output logic [1:0]              pin_dir_o,
    output logic                    mst_busy_o,
    output logic                    mst_done_o,
    output logic                    mst_abort_o,
    output logic                    mst_nack_o,
    output logic                    slave_irq_o,
    output logic                    wake_o
);

    //--------------------------------------------------------------
    // Pin synchronisers and bus event detection
    //--------------------------------------------------------------
    psc_pins_type      pins_s1_q;
    psc_pins_type      pins_s2_q;
    psc_pins_type      pins_prev_q;
    logic              scl_rise;
    logic              scl_fall;
    logic              start_det;
    logic              stop_det;

    // Bus wires are asynchronous; two stages before any logic looks
    always_ff @(posedge sys_clk_i or negedge reset_n_i)
    begin
        if (!reset_n_i)
        begin
            pins_s1_q   <= '1;
            pins_s2_q   <= '1;
            pins_prev_q <= '1;
        end
        else
        begin
            pins_s1_q   <= pins_in_i;
            pins_s2_q   <= pins_s1_q;
            pins_prev_q <= pins_s2_q;
        end
    end

    // Edges of the serial clock and start/stop framing
    assign scl_rise  = pins_s2_q.scl & ~pins_prev_q.scl;
    assign scl_fall  = ~pins_s2_q.scl & pins_prev_q.scl;
    assign start_det = pins_s2_q.scl & pins_prev_q.scl & pins_prev_q.sda & ~pins_s2_q.sda;
    assign stop_det  = pins_s2_q.scl & pins_prev_q.scl & ~pins_prev_q.sda & pins_s2_q.sda;

    //--------------------------------------------------------------
    // Enable and power state
    //--------------------------------------------------------------
    logic              module_on_q;
    logic              idle_stop;
    logic              mst_run;
    logic              idle_stop_prev_q;
    logic              idle_stop_entry;

    // Reset always leaves the module off until software enables it
    always_ff @(posedge sys_clk_i or negedge reset_n_i)
    begin
        if (!reset_n_i)
            module_on_q <= 1'b0; // R11
        else
            module_on_q <= module_enable_i;
    end

    // Idle only stops the module when the select bit asks for it
    assign idle_stop = idle_i & bus_control_register_i[`PSC_CON_SIDL_BIT]; // R9
    // Master side and generator only advance while their clock would run
    assign mst_run   = module_on_q & ~sleep_i & ~idle_stop; // R1 R8 R10

    always_ff @(posedge sys_clk_i or negedge reset_n_i)
    begin
        if (!reset_n_i)
            idle_stop_prev_q <= 1'b0;
        else
            idle_stop_prev_q <= idle_stop;
    end

    assign idle_stop_entry = idle_stop & ~idle_stop_prev_q; // R10

    //--------------------------------------------------------------
    // Master: bit-rate generator and transfer sequencer
    //--------------------------------------------------------------
    psc_mst_state_type mst_state_q;
    logic [BRG_W-1:0]  brg_q;
    logic              brg_tick;
    logic [3:0]        bit_cnt_q;
    logic [7:0]        mst_sh_q;
    logic              mst_scl_low_q;
    logic              mst_sda_low_q;
    logic              mst_done_q;
    logic              mst_abort_q;
    logic              mst_nack_q;

    // Generator halts at its reload value whenever the master is stopped
    always_ff @(posedge sys_clk_i or negedge reset_n_i)
    begin
        if (!reset_n_i)
            brg_q <= '0;
        else if (!mst_run || mst_state_q == M_IDLE || brg_q == '0)
            brg_q <= mst_brg_reload_i; // R1 R14
        else
            brg_q <= brg_q - 1'b1;
    end

    assign brg_tick = mst_run && mst_state_q != M_IDLE && brg_q == '0;

    // Losing the clock mid-transfer drops the transfer; no resume exists
    always_ff @(posedge sys_clk_i or negedge reset_n_i)
    begin
        if (!reset_n_i)
        begin
            mst_state_q   <= M_IDLE;
            bit_cnt_q     <= `PSC_BIT_FIRST;
            mst_sh_q      <= `PSC_SHIFT_RST;
            mst_scl_low_q <= 1'b0;
            mst_sda_low_q <= 1'b0;
            mst_done_q    <= 1'b0;
            mst_abort_q   <= 1'b0;
        end
        else
        begin
            mst_done_q  <= 1'b0;
            mst_abort_q <= 1'b0;
            if (!mst_run)
            begin
                mst_abort_q   <= mst_state_q != M_IDLE; // R2
                mst_state_q   <= M_IDLE; // R14
                mst_scl_low_q <= 1'b0;
                mst_sda_low_q <= 1'b0;
            end
            else
            begin
                unique case (mst_state_q)
                    M_IDLE:
                    begin
                        if (mst_start_i)
                        begin
                            mst_sh_q      <= mst_data_i;
                            bit_cnt_q     <= `PSC_BIT_FIRST;
                            mst_sda_low_q <= 1'b1;
                            mst_state_q   <= M_START;
                        end
                    end
                    M_START:
                    begin
                        if (brg_tick)
                        begin
                            mst_scl_low_q <= 1'b1;
                            mst_sda_low_q <= ~mst_sh_q[7];
                            mst_state_q   <= M_LOW;
                        end
                    end
                    M_LOW:
                    begin
                        if (brg_tick)
                        begin
                            mst_scl_low_q <= 1'b0;
                            mst_state_q   <= M_HIGH;
                        end
                    end
                    M_HIGH:
                    begin
                        if (brg_tick)
                        begin
                            mst_scl_low_q <= 1'b1;
                            if (bit_cnt_q == `PSC_BIT_ACK)
                            begin
                                mst_sda_low_q <= 1'b1;
                                mst_state_q   <= M_STOP;
                            end
                            else
                            begin
                                bit_cnt_q     <= bit_cnt_q + 1'b1;
                                mst_sh_q      <= {mst_sh_q[6:0], 1'b0};
                                mst_sda_low_q <= (bit_cnt_q == `PSC_ADDR_LAST) ? 1'b0 : ~mst_sh_q[6];
                                mst_state_q   <= M_LOW;
                            end
                        end
                    end
                    M_STOP:
                    begin
                        if (brg_tick)
                        begin
                            mst_scl_low_q <= 1'b0;
                            mst_state_q   <= M_STOPH;
                        end
                    end
                    M_STOPH:
                    begin
                        if (brg_tick)
                        begin
                            mst_sda_low_q <= 1'b0;
                            mst_done_q    <= 1'b1;
                            mst_state_q   <= M_IDLE;
                        end
                    end
                endcase
            end
        end
    end

    // Acknowledge result is only touched by a running master
    always_ff @(posedge sys_clk_i or negedge reset_n_i)
    begin
        if (!reset_n_i)
            mst_nack_q <= 1'b0;
        else if (brg_tick && mst_state_q == M_HIGH && bit_cnt_q == `PSC_BIT_ACK)
            mst_nack_q <= pins_s2_q.sda; // R4
    end

    //--------------------------------------------------------------
    // Slave: address match, runs on bus clock edges even in sleep
    //--------------------------------------------------------------
    psc_slv_state_type slv_state_q;
    logic [3:0]        slv_cnt_q;
    logic [7:0]        slv_sh_q;
    logic              slv_ack_q;
    logic              slv_match;
    logic              slv_irq_q;
    logic              wake_q;

    assign slv_match = slv_state_q == S_ADDR && scl_rise && slv_cnt_q == `PSC_ADDR_LAST
                       && slv_sh_q[6:0] == slave_addr_i;

    // Sleep does not gate this machine; the external master's clock drives it
    always_ff @(posedge sys_clk_i or negedge reset_n_i)
    begin
        if (!reset_n_i)
        begin
            slv_state_q <= S_IDLE;
            slv_cnt_q   <= `PSC_BIT_FIRST;
            slv_sh_q    <= `PSC_SHIFT_RST;
            slv_ack_q   <= 1'b0;
        end
        else if (!module_on_q || idle_stop_entry || stop_det)
        begin
            slv_state_q <= S_IDLE; // R10 R11
            slv_ack_q   <= 1'b0;
        end
        else if (start_det)
        begin
            slv_state_q <= S_ADDR; // R5
            slv_cnt_q   <= `PSC_BIT_FIRST;
            slv_ack_q   <= 1'b0;
        end
        else
        begin
            unique case (slv_state_q)
                S_IDLE: ;
                S_ADDR:
                begin
                    if (scl_rise)
                    begin
                        slv_sh_q  <= {slv_sh_q[6:0], pins_s2_q.sda};
                        slv_cnt_q <= slv_cnt_q + 1'b1;
                        if (slv_cnt_q == `PSC_ADDR_LAST)
                            slv_state_q <= slv_match ? S_ACK : S_WAIT;
                    end
                end
                S_ACK:
                begin
                    if (scl_fall)
                    begin
                        slv_ack_q <= ~slv_ack_q;
                        if (slv_ack_q)
                            slv_state_q <= S_WAIT;
                    end
                end
                S_WAIT: ;
            endcase
        end
    end

    // Address match is the slave's only interrupt; wake needs it enabled
    always_ff @(posedge sys_clk_i or negedge reset_n_i)
    begin
        if (!reset_n_i)
        begin
            slv_irq_q <= 1'b0;
            wake_q    <= 1'b0;
        end
        else
        begin
            slv_irq_q <= slv_match && module_on_q; // R6
            wake_q    <= slv_match && module_on_q && slave_irq_en_i && (sleep_i || idle_stop); // R6
        end
    end

    //--------------------------------------------------------------
    // Pin drive
    //--------------------------------------------------------------
    // Open drain: the data value is always low, only the enable moves
    assign pins_out_o    = '{scl: `PSC_PIN_LOW, sda: `PSC_PIN_LOW}; // R13
    // One driver for the whole enable struct keeps it a single continuous assignment
    assign pins_oe_o     = '{scl: module_on_q & mst_scl_low_q,
                             sda: module_on_q & (mst_sda_low_q | slv_ack_q)}; // R13
    // General-purpose direction only applies while the bus function is off
    assign pin_dir_o     = module_on_q ? `PSC_OD_DIR : pin_direction_bits_i; // R12

    assign mst_busy_o  = mst_state_q != M_IDLE;
    assign mst_done_o  = mst_done_q;
    assign mst_abort_o = mst_abort_q;
    assign mst_nack_o  = mst_nack_q;
    assign slave_irq_o = slv_irq_q;
    assign wake_o      = wake_q;

    //--------------------------------------------------------------
    // Assertions
    //--------------------------------------------------------------
    sleep_halt_a: assert property ( // R1
        @(posedge sys_clk_i) disable iff (!reset_n_i)
        sleep_i |=> mst_state_q == M_IDLE && brg_q == $past(mst_brg_reload_i))
        else $error("master or generator ran during sleep");

    abort_pulse_a: assert property ( // R2
        @(posedge sys_clk_i) disable iff (!reset_n_i)
        (!mst_run && mst_state_q != M_IDLE) |=> mst_abort_o ##1 !mst_abort_o)
        else $error("transfer stop without single abort pulse");

    nack_keep_a: assert property ( // R4
        @(posedge sys_clk_i) disable iff (!reset_n_i)
        (sleep_i && $past(sleep_i)) |-> $stable(mst_nack_o))
        else $error("state changed across sleep");

    slave_sleep_a: assert property ( // R5
        @(posedge sys_clk_i) disable iff (!reset_n_i)
        (sleep_i && module_on_q && start_det && !stop_det) |=> slv_state_q == S_ADDR)
        else $error("slave did not follow bus in sleep");

    wake_cause_a: assert property ( // R6
        @(posedge sys_clk_i) disable iff (!reset_n_i)
        wake_o |-> $past(slv_match) && $past(slave_irq_en_i) && slave_irq_o)
        else $error("wake without enabled address match");

    idle_select_a: assert property ( // R9
        @(posedge sys_clk_i) disable iff (!reset_n_i)
        (module_on_q && !sleep_i) |-> mst_run == !(idle_i && bus_control_register_i[`PSC_CON_SIDL_BIT]))
        else $error("idle select bit not honoured");

    idle_reset_a: assert property ( // R10
        @(posedge sys_clk_i) disable iff (!reset_n_i)
        idle_stop_entry |=> slv_state_q == S_IDLE && mst_state_q == M_IDLE)
        else $error("machines not reset on idle stop");

    reset_off_a: assert property ( // R11
        @(posedge sys_clk_i) disable iff (!reset_n_i)
        !module_on_q |-> !pins_oe_o.scl && !pins_oe_o.sda)
        else $error("disabled module drives the bus");

    dir_override_a: assert property ( // R12
        @(posedge sys_clk_i) disable iff (!reset_n_i)
        module_on_q |-> pin_dir_o == `PSC_OD_DIR)
        else $error("direction bits not overridden");

    open_drain_a: assert property ( // R13
        @(posedge sys_clk_i) disable iff (!reset_n_i)
        pins_out_o == '0)
        else $error("pin driven high");

endmodule

/* File: verif/psc_bus_partner.sv */
`timescale 1ns/1ps
// Far side of the bus: one external master for address frames, one receiver
// that acknowledges bytes written by the block's own master
module psc_bus_partner
    import psc_pkg::*;
(
    input  wire logic         ack_en_i,
    input  wire psc_pins_type dut_oe_i,
    output psc_pins_type      wire_o,
    output logic [7:0]        rx_byte_o,
    output logic              addr_acked_o
);
    localparam realtime HALF = 62.5;
    logic         scl_low = 1'b0;
    logic         sda_low = 1'b0;
    logic         sda_ack = 1'b0;
    logic         driving = 1'b0;
    int           bit_cnt = 9;
    psc_pins_type prev    = 2'h3;

    // Pull-ups hold both wires high unless some party sinks them
    assign wire_o = {~(dut_oe_i.scl | scl_low), ~(dut_oe_i.sda | sda_low | sda_ack)};

    initial rx_byte_o = 8'h00;
    initial addr_acked_o = 1'b0;

    // Receiver: shift on clock rise after a start, sink data in the ninth clock
    always @(wire_o)
    begin
        if (!driving && prev.scl && wire_o.scl && prev.sda && !wire_o.sda)
            bit_cnt = 0;
        else if (!driving && !prev.scl && wire_o.scl && bit_cnt < 8)
        begin
            rx_byte_o = {rx_byte_o[6:0], wire_o.sda};
            bit_cnt++;
        end
        else if (prev.scl && !wire_o.scl)
        begin
            sda_ack = (bit_cnt == 8) && ack_en_i;
            if (bit_cnt == 8)
                bit_cnt = 9;
        end
        prev = wire_o;
    end

    // External master: start, eight bits MSB first, ack clock, stop.
    // Clock stands high outside frames; period is 125 ns.
    task automatic send_addr(input logic [7:0] ab);
        driving = 1'b1;
        sda_low = 1'b1;
        #HALF;
        for (int i = 7; i >= 0; i--)
        begin
            scl_low = 1'b1;
            #(HALF / 2);
            sda_low = ~ab[i];
            #(HALF / 2);
            scl_low = 1'b0;
            #HALF;
        end
        scl_low = 1'b1;
        #(HALF / 2);
        sda_low = 1'b0;
        #(HALF / 2);
        scl_low = 1'b0;
        #(HALF / 2);
        addr_acked_o = ~wire_o.sda;
        #(HALF / 2);
        scl_low = 1'b1;
        #(HALF / 2);
        sda_low = 1'b1;
        #(HALF / 2);
        scl_low = 1'b0;
        #(HALF / 2);
        sda_low = 1'b0;
        #HALF;
        driving = 1'b0;
    endtask
endmodule

/* File: verif/test_i2c_power_save_reset_control.sv */
`timescale 1ns/1ps
`include "psc_regs.svh"
module test_i2c_power_save_reset_control
    import psc_pkg::*;
();
    localparam int RELOAD = 3;
    localparam int LIMIT  = 20000;
    // Row: mode {sleep, idle, stop_in_idle, irq_en}, address byte, {irq, wake, ack}
    typedef struct packed {
        logic [3:0] mode;
        logic [7:0] ab;
        logic [2:0] exp;
    } psc_row_type;
    psc_row_type rows [6] = '{'{4'h1, 8'h54, 3'h5}, '{4'h9, 8'h54, 3'h7}, '{4'h9, 8'h66, 3'h0},
                              '{4'h8, 8'h54, 3'h5}, '{4'h7, 8'h54, 3'h7}, '{4'h5, 8'h54, 3'h5}};
    logic         sys_clk_i = 1'b0, reset_n_i = 1'b0, module_enable_i = 1'b1;
    logic         sleep_i = 1'b0, idle_i = 1'b0, mst_start_i = 1'b0, slave_irq_en_i = 1'b0;
    logic [15:0]  bus_control_register_i = 16'h0000;
    logic [7:0]   mst_data_i = 8'h00, rx_byte;
    logic [1:0]   pin_direction_bits_i = 2'h1, pin_dir_o;
    logic         partner_ack = 1'b1, addr_acked, mst_busy_o, mst_done_o, mst_abort_o;
    logic         mst_nack_o, slave_irq_o, wake_o;
    logic         irq_seen, wake_seen, done_seen, abort_seen;
    psc_pins_type bus_lv, pins_out_o, pins_oe_o;
    int           fails = 0, tests_run = 0, cycles = 0;

    always #2 sys_clk_i = ~sys_clk_i;

    psc_power_ctl #(.BRG_W(12)) uut (
        .sys_clk_i(sys_clk_i), .reset_n_i(reset_n_i), .module_enable_i(module_enable_i),
        .sleep_i(sleep_i), .idle_i(idle_i), .bus_control_register_i(bus_control_register_i),
        .mst_brg_reload_i(12'(RELOAD)), .mst_start_i(mst_start_i), .mst_data_i(mst_data_i),
        .slave_addr_i(7'h2a), .slave_irq_en_i(slave_irq_en_i), .pin_direction_bits_i(pin_direction_bits_i),
        .pins_in_i(bus_lv), .pins_out_o(pins_out_o), .pins_oe_o(pins_oe_o), .pin_dir_o(pin_dir_o),
        .mst_busy_o(mst_busy_o), .mst_done_o(mst_done_o), .mst_abort_o(mst_abort_o),
        .mst_nack_o(mst_nack_o), .slave_irq_o(slave_irq_o), .wake_o(wake_o));

    psc_bus_partner partner (.ack_en_i(partner_ack), .dut_oe_i(pins_oe_o), .wire_o(bus_lv),
        .rx_byte_o(rx_byte), .addr_acked_o(addr_acked));

    // ----------------------------------------
    // Checking and helpers
    // ----------------------------------------
    task automatic print_verdict();
        if (fails == 0 && tests_run > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask

    task automatic check_bit(input string nm, input logic e, input logic g);
        tests_run++;
        if (g !== e)
        begin
            fails++;
            $display("unexpected %s: expected %b seen %b", nm, e, g);
        end
    endtask

    task automatic check_vec(input string nm, input logic [7:0] e, input logic [7:0] g);
        tests_run++;
        if (g !== e)
        begin
            fails++;
            $display("unexpected %s: expected %h seen %h", nm, e, g);
        end
    endtask

    task automatic check_cnt(input string nm, input int e, input int g);
        tests_run++;
        if (g != e)
        begin
            fails++;
            $display("unexpected %s: expected %0d seen %0d", nm, e, g);
        end
    endtask

    // Pulses last one cycle, so they are caught at the falling edge; also the hang guard
    always @(negedge sys_clk_i)
    begin
        if (slave_irq_o === 1'b1) irq_seen = 1'b1;
        if (wake_o === 1'b1) wake_seen = 1'b1;
        if (mst_done_o === 1'b1) done_seen = 1'b1;
        if (mst_abort_o === 1'b1) abort_seen = 1'b1;
        cycles++;
        if (cycles == LIMIT)
        begin
            fails++;
            print_verdict();
        end
    end

    task automatic kick(input logic [7:0] d);
        @(negedge sys_clk_i);
        mst_data_i = d;
        mst_start_i = 1'b1;
        @(negedge sys_clk_i);
        mst_start_i = 1'b0;
    endtask

    task automatic do_write(input logic [7:0] d, input logic ack, input logic nk);
        int n;
        done_seen = 1'b0;
        partner_ack = ack;
        kick(d);
        n = 0;
        while (pins_oe_o.scl !== 1'b1 && n < 100)
        begin
            @(negedge sys_clk_i);
            n++;
        end
        check_cnt("scl_delay", RELOAD + 1, n);
        n = 0;
        while (done_seen !== 1'b1 && n < 400)
        begin
            @(negedge sys_clk_i);
            n++;
        end
        check_bit("done", 1'b1, done_seen);
        check_vec("rx_byte", d, rx_byte);
        check_bit("nack", nk, mst_nack_o);
        check_vec("pins_out", 8'h00, {6'h0, pins_out_o});
    endtask

    // ----------------------------------------
    // Main sequence
    // ----------------------------------------
    initial
    begin
        repeat (2) @(negedge sys_clk_i);
        check_vec("pin_dir_rst", 8'h01, {6'h0, pin_dir_o});
        check_vec("oe_rst", 8'h00, {6'h0, pins_oe_o});
        reset_n_i = 1'b1;
        repeat (3) @(negedge sys_clk_i);
        check_vec("pin_dir_on", 8'h03, {6'h0, pin_dir_o});
        // Address frames in the power states; no slave data phase is under way
        foreach (rows[i])
        begin
            {sleep_i, idle_i} = rows[i].mode[3:2];
            bus_control_register_i[`PSC_CON_SIDL_BIT] = rows[i].mode[1];
            slave_irq_en_i = rows[i].mode[0];
            irq_seen = 1'b0;
            wake_seen = 1'b0;
            partner.send_addr(rows[i].ab);
            repeat (4) @(negedge sys_clk_i);
            check_bit("slave_irq", rows[i].exp[2], irq_seen);
            check_bit("wake", rows[i].exp[1], wake_seen);
            check_bit("addr_ack", rows[i].exp[0], addr_acked);
        end
        {sleep_i, idle_i} = 2'h0;
        do_write(8'ha5, 1'b1, 1'b0);
        do_write(8'h3c, 1'b0, 1'b1);
        // Sleep mid-transfer, refused start while asleep, clean restart afterwards
        kick(8'hc3);
        repeat (20) @(negedge sys_clk_i);
        sleep_i = 1'b1;
        @(negedge sys_clk_i);
        check_bit("busy_sleep", 1'b0, mst_busy_o);
        check_bit("abort_sleep", 1'b1, mst_abort_o);
        check_vec("oe_sleep", 8'h00, {6'h0, pins_oe_o});
        kick(8'hff);
        check_bit("busy_asleep", 1'b0, mst_busy_o);
        sleep_i = 1'b0;
        check_bit("nack_sleep", 1'b1, mst_nack_o);
        do_write(8'h96, 1'b1, 1'b0);
        // Stop in idle aborts; running in idle completes
        bus_control_register_i[`PSC_CON_SIDL_BIT] = 1'b1;
        kick(8'h5a);
        repeat (20) @(negedge sys_clk_i);
        idle_i = 1'b1;
        @(negedge sys_clk_i);
        check_bit("abort_idle", 1'b1, mst_abort_o);
        // Idle stays on while the select bit flips; let the abort pulse pass first
        bus_control_register_i[`PSC_CON_SIDL_BIT] = 1'b0;
        @(negedge sys_clk_i);
        abort_seen = 1'b0;
        do_write(8'h81, 1'b1, 1'b0);
        check_bit("abort_run", 1'b0, abort_seen);
        idle_i = 1'b0;
        // Disable mid-transfer hands the pins back
        pin_direction_bits_i = 2'h2;
        kick(8'h77);
        repeat (20) @(negedge sys_clk_i);
        module_enable_i = 1'b0;
        repeat (3) @(negedge sys_clk_i);
        check_bit("abort_off", 1'b1, abort_seen);
        check_vec("pin_dir_off", 8'h02, {6'h0, pin_dir_o});
        check_vec("oe_off", 8'h00, {6'h0, pins_oe_o});
        // Reset in mid-transfer ends it at once
        module_enable_i = 1'b1;
        repeat (2) @(negedge sys_clk_i);
        kick(8'h0f);
        repeat (20) @(negedge sys_clk_i);
        reset_n_i = 1'b0;
        #1;
        check_bit("busy_rst", 1'b0, mst_busy_o);
        check_vec("oe_mid_rst", 8'h00, {6'h0, pins_oe_o});
        @(negedge sys_clk_i);
        reset_n_i = 1'b1;
        repeat (3) @(negedge sys_clk_i);
        do_write(8'he7, 1'b1, 1'b0);
        print_verdict();
    end
endmodule
